// ---- rtl/flg_pkg.sv ----
// constants, types and decoding shared by the flash lock access guard
// What this block does
// - from a locked page, unlocked pages other than the lock-byte page are accessible
// - from a locked page, locked pages other than the lock-byte page are accessible
// - erasing the lock-byte page never happens; an unlocked attempt raises a flash-error reset
// - the lock-byte page may only be read or written
// - the lock byte can always be read
// - lock-byte bits may not be cleared from one to zero
// - lock-byte bits may not be returned from zero to one
// - reserved area reads, writes and erases are refused
// - any reserved area access raises a flash-error reset
// - program store control register, 2 bits, reset zero, bit1 erase, bit0 write
// - write enable steers stores to flash and stays set until cleared
// - erase needs both enables; a store erases its whole 512-byte page to 0xff
// - a flash write only clears bits; only an erase sets them
package flg_pkg;

    // flash geometry
    localparam int unsigned FLASH_BYTES  = 8192;
    localparam int unsigned ADDR_W       = 13;
    localparam int unsigned PAGE_BYTES   = 512;
    localparam int unsigned PAGE_LSB     = 9;
    localparam int unsigned PAGE_W       = 4;
    localparam logic [12:0] LOCK_BYTE_ADDR = 13'h1dff;
    localparam logic [3:0]  LOCK_PAGE      = 4'he;
    localparam logic [3:0]  RESERVED_PAGE  = 4'hf;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;

    // unlock keys
    localparam logic [7:0]  KEY_FIRST  = 8'ha5;
    localparam logic [7:0]  KEY_SECOND = 8'hf1;

    // register word indices; byte address is four times the index
    localparam logic [9:0]  IDX_PROGRAM_STORE_CONTROL  = 10'h08f;
    localparam logic [9:0]  IDX_KEY    = 10'h090;
    localparam logic [9:0]  IDX_STATUS = 10'h091;
    localparam logic [9:0]  IDX_MASK   = 10'h092;
    localparam logic [9:0]  IDX_LOCK   = 10'h093;
    localparam logic [1:0]  PROGRAM_STORE_CONTROL_RESET = 2'h0;
    localparam int unsigned PROGRAM_STORE_CONTROL_WE_BIT = 0;
    localparam int unsigned PROGRAM_STORE_CONTROL_EE_BIT = 1;

    // interrupt status layout
    localparam int unsigned ST_W          = 4;
    localparam int unsigned ST_FLASH_ERR  = 0;
    localparam int unsigned ST_NO_KEY     = 1;
    localparam int unsigned ST_LOCK_GUARD = 2;
    localparam int unsigned ST_OP_DONE    = 3;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b10
    } flg_key_t;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_READ  = 2'b01,
        OP_PROG  = 2'b10,
        OP_ERASE = 2'b11
    } flg_op_t;

    typedef struct packed {
        logic              valid;
        logic              store;   // 1: external_data_move store, 0: code read
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } flg_cpu_req_t;

    typedef struct packed {
        logic       valid;
        logic       refused;
        logic [7:0] data;
    } flg_cpu_rsp_t;

    typedef struct packed {
        flg_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } flg_cmd_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } flg_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } flg_wb_rsp_t;

    function automatic logic [PAGE_W-1:0] flg_page_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:PAGE_LSB];
    endfunction

    function automatic logic flg_is_reserved(input logic [ADDR_W-1:0] a);
        return flg_page_of(a) == RESERVED_PAGE;
    endfunction

endpackage

// ---- rtl/flg_flash_array.sv ----
// flash byte array with program (clear only) and page erase
`timescale 1ns/1ps
module flg_flash_array
    import flg_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // command from the guard
    input  wire flg_cmd_t   cmd,
    // results
    output logic [7:0]      rdata,
    output logic [7:0]      lock_byte
);

    logic [7:0] mem [FLASH_BYTES];   // nonvolatile contents, not reset
    logic [7:0] rdata_r;
    logic [7:0] lock_r;              // shadow of the lock byte so checks need no read port

    // contents; erase loops the page so it completes in one cycle
    always_ff @(posedge clock) begin
        if (cmd.op == OP_PROG) begin
            mem[cmd.addr] <= mem[cmd.addr] & cmd.data;
        end else if (cmd.op == OP_ERASE) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                mem[{flg_page_of(cmd.addr), i[PAGE_LSB-1:0]}] <= ERASED_BYTE;
            end
        end
    end

    // read data and lock shadow
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
            lock_r  <= ERASED_BYTE;
        end else begin
            if (cmd.op == OP_READ) begin
                rdata_r <= (cmd.addr == LOCK_BYTE_ADDR) ? lock_r : mem[cmd.addr];
            end
            if (cmd.op == OP_PROG && cmd.addr == LOCK_BYTE_ADDR) begin
                lock_r <= lock_r & cmd.data;
            end else if (cmd.op == OP_ERASE && flg_page_of(cmd.addr) == LOCK_PAGE) begin
                lock_r <= ERASED_BYTE;
            end
        end
    end

    assign rdata     = rdata_r;
    assign lock_byte = lock_r;

endmodule // flg_flash_array

// ---- rtl/flg_guard.sv ----
// access guard, key sequencer and register slave for firmware flash stores
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module flg_guard
    import flg_pkg::*;
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // wishbone register slave
    input  wire flg_wb_req_t  wb_req,
    output flg_wb_rsp_t       wb_rsp,
    // firmware flash access port
    input  wire flg_cpu_req_t cpu_req,
    output flg_cpu_rsp_t      cpu_rsp,
    // system outputs
    output logic              flash_error_reset,
    output logic              irq
);

    typedef struct packed {
        logic            store_write_enable;
        logic            store_erase_enable;
        flg_key_t        key;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic            ack;
        logic [31:0]     rdat;
        logic            err;
        logic            rsp_valid;
        logic            rsp_refused;
    } flg_state_t;

    flg_state_t s_r;
    flg_state_t s_nxt;
    flg_cmd_t   cmd;
    logic [7:0] flash_rdata;
    logic [7:0] lock_byte;

    // decode of the current access
    logic [9:0]        idx;
    logic              wb_hit;
    logic              wb_wr;
    logic              flash_store;
    logic              flash_acc;
    logic              lock_pg;
    logic              armed;
    logic              ev_err;
    logic              ev_nokey;
    logic              ev_guard;
    logic              ev_done;
    logic [ST_W-1:0]   st_set;
    logic [ST_W-1:0]   st_clr;

    assign idx         = wb_req.adr[11:2];
    assign wb_hit      = wb_req.cyc & wb_req.stb & ~s_r.ack;
    assign wb_wr       = wb_hit & wb_req.we & wb_req.sel[0];
    assign flash_store = cpu_req.valid & cpu_req.store & s_r.store_write_enable;
    assign flash_acc   = flash_store | (cpu_req.valid & ~cpu_req.store);
    assign lock_pg     = flg_page_of(cpu_req.addr) == LOCK_PAGE;
    assign armed       = s_r.key == KEY_ARMED;

    // the array applies the chosen command at the next edge; operations are
    // single cycle here, real program and erase times are not modelled
    flg_flash_array u_array (
        .clock     (clock),
        .rst       (rst),
        .cmd       (cmd),
        .rdata     (flash_rdata),
        .lock_byte (lock_byte)
    );

    // permission check ahead of any operation; the first matching case wins
    // order of the checks, highest first:
    //   reserved page, read or flash store: reset pulse, nothing starts
    //   flash store without an armed unlock: ignored, flagged
    //   erase aimed at the lock-byte page: reset pulse, page kept
    //   erase of any other page, locked or not: page set to erased
    //   program that would change the lock byte: ignored, flagged, no reset
    //   any other program: clears bits only
    //   code read: always answered, the lock byte from its shadow
    // the lock state of a page is not consulted: from a locked page every
    // page but the lock-byte page is open, so only position matters
    always_comb begin
        cmd.op   = OP_NONE;
        cmd.addr = cpu_req.addr;
        cmd.data = cpu_req.data;
        ev_err   = 1'b0;
        ev_nokey = 1'b0;
        ev_guard = 1'b0;
        ev_done  = 1'b0;
        if (flash_acc && flg_is_reserved(cpu_req.addr)) begin
            ev_err = 1'b1;
        end else if (flash_store && !armed) begin
            ev_nokey = 1'b1;
        end else if (flash_store && s_r.store_erase_enable && lock_pg) begin
            ev_err = 1'b1;
        end else if (flash_store && s_r.store_erase_enable) begin
            cmd.op  = OP_ERASE;
            ev_done = 1'b1;
        end else if (flash_store && cpu_req.addr == LOCK_BYTE_ADDR
                     && (cpu_req.data & lock_byte) != lock_byte) begin
            ev_guard = 1'b1;
        end else if (flash_store) begin
            cmd.op  = OP_PROG;
            ev_done = 1'b1;
        end else if (flash_acc) begin
            cmd.op = OP_READ;
        end
    end

    assign st_set = {ev_done, ev_guard, ev_nokey, ev_err};
    assign st_clr = (wb_wr && idx == IDX_STATUS) ? wb_req.dat[ST_W-1:0] : '0;

    // register map by word index:
    //   program store control: bit0 write enable, bit1 erase enable
    //   unlock key: write keys, read back the sequencer state
    //   status: sticky events, write one to clear
    //   mask: same layout as status, gates irq
    //   lock: read-only copy of the lock byte
    // a wrong key or a key written while armed drops back to idle
    // next state: registers, key sequence, events and bus answer
    always_comb begin
        s_nxt             = s_r;
        s_nxt.ack         = wb_hit;
        s_nxt.err         = ev_err;
        s_nxt.rsp_valid   = cpu_req.valid & flash_acc;
        s_nxt.rsp_refused = ev_err | ev_nokey | ev_guard;
        // a set in the same cycle as its clear is kept
        s_nxt.status      = (s_r.status & ~st_clr) | st_set;
        if (wb_wr) begin
            case (idx)
                IDX_PROGRAM_STORE_CONTROL: begin
                    s_nxt.store_write_enable = wb_req.dat[PROGRAM_STORE_CONTROL_WE_BIT];
                    s_nxt.store_erase_enable = wb_req.dat[PROGRAM_STORE_CONTROL_EE_BIT];
                end
                IDX_MASK: begin
                    s_nxt.mask = wb_req.dat[ST_W-1:0];
                end
                IDX_KEY: begin
                    case (s_r.key)
                        KEY_IDLE: s_nxt.key = (wb_req.dat[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                        KEY_HALF: s_nxt.key = (wb_req.dat[7:0] == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
                        default:  s_nxt.key = KEY_IDLE;
                    endcase
                end
                default: begin
                end
            endcase
        end
        // each flash store (write enable set) uses up the unlock, right or wrong
        if (flash_store) begin
            s_nxt.key = KEY_IDLE;
        end
        s_nxt.rdat = 32'h0000_0000;
        if (wb_hit && !wb_req.we) begin
            case (idx)
                IDX_PROGRAM_STORE_CONTROL:  s_nxt.rdat[1:0] = {s_r.store_erase_enable, s_r.store_write_enable};
                IDX_KEY:    s_nxt.rdat[1:0] = s_r.key;
                IDX_STATUS: s_nxt.rdat[ST_W-1:0] = s_r.status;
                IDX_MASK:   s_nxt.rdat[ST_W-1:0] = s_r.mask;
                IDX_LOCK:   s_nxt.rdat[7:0] = lock_byte;
                default:    s_nxt.rdat = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r.store_write_enable <= PROGRAM_STORE_CONTROL_RESET[PROGRAM_STORE_CONTROL_WE_BIT];
            s_r.store_erase_enable <= PROGRAM_STORE_CONTROL_RESET[PROGRAM_STORE_CONTROL_EE_BIT];
            s_r.key                <= KEY_IDLE;
            s_r.status             <= '0;
            s_r.mask               <= '0;
            s_r.ack                <= 1'b0;
            s_r.rdat               <= 32'h0000_0000;
            s_r.err                <= 1'b0;
            s_r.rsp_valid          <= 1'b0;
            s_r.rsp_refused        <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs; irq is a level from registers
    // the reset pulse clears nothing here: the system reset that it triggers
    // does, so the pulse is only one cycle wide
    assign wb_rsp.ack        = s_r.ack;
    assign wb_rsp.dat        = s_r.rdat;
    assign cpu_rsp.valid     = s_r.rsp_valid;
    assign cpu_rsp.refused   = s_r.rsp_refused;
    assign cpu_rsp.data      = s_r.rsp_refused ? 8'h00 : flash_rdata;
    assign flash_error_reset = s_r.err;
    assign irq               = |(s_r.status & s_r.mask);

    // checks
    // any reserved access starts nothing and pulses the reset
    a_reserved_reset: assert property (@(posedge clock) disable iff (rst)
        flash_acc && flg_is_reserved(cpu_req.addr) |-> cmd.op == OP_NONE ##1 flash_error_reset)
        else $error("reserved access did not reset");

    // an unlocked erase of the lock-byte page never reaches the array
    a_lock_erase_reset: assert property (@(posedge clock) disable iff (rst)
        flash_store && armed && s_r.store_erase_enable && lock_pg
        |-> cmd.op != OP_ERASE ##1 (flash_error_reset && status_err_set()))
        else $error("lock page erase not blocked");

    // reserved stores are excluded: the reset check outranks the key check
    a_no_key_ignore: assert property (@(posedge clock) disable iff (rst)
        flash_store && !armed && !flg_is_reserved(cpu_req.addr)
        |-> cmd.op == OP_NONE ##1 (s_r.status[ST_NO_KEY] && cpu_rsp.refused))
        else $error("store without key reached flash");

    // a program of the lock byte never clears a bit of it
    a_lock_byte_guard: assert property (@(posedge clock) disable iff (rst)
        cmd.op == OP_PROG && cmd.addr == LOCK_BYTE_ADDR |-> (cmd.data & lock_byte) == lock_byte)
        else $error("lock byte changed");

    // an erase only with both enables, an armed key and outside the lock page
    a_erase_enables: assert property (@(posedge clock) disable iff (rst)
        cmd.op == OP_ERASE |-> s_r.store_write_enable && s_r.store_erase_enable && armed && !lock_pg)
        else $error("erase without both enables");

    // every flash store spends the unlock
    a_key_consumed: assert property (@(posedge clock) disable iff (rst)
        flash_store |=> s_r.key == KEY_IDLE)
        else $error("unlock survived a store");

    // a control register write lands with its ack
    a_program_store_control_write: assert property (@(posedge clock) disable iff (rst)
        wb_wr && idx == IDX_PROGRAM_STORE_CONTROL |=> wb_rsp.ack
        && s_r.store_write_enable == $past(wb_req.dat[PROGRAM_STORE_CONTROL_WE_BIT])
        && s_r.store_erase_enable == $past(wb_req.dat[PROGRAM_STORE_CONTROL_EE_BIT]))
        else $error("control register write lost");

    // ack is a single cycle pulse
    a_wb_ack_pulse: assert property (@(posedge clock) disable iff (rst)
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held two cycles");

    // every taken request is answered in the next cycle
    a_ack_answer: assert property (@(posedge clock) disable iff (rst)
        wb_hit |=> wb_rsp.ack)
        else $error("request not acknowledged");

    // reads outside the reserved page are always answered
    a_read_answer: assert property (@(posedge clock) disable iff (rst)
        cpu_req.valid && !cpu_req.store && !flg_is_reserved(cpu_req.addr)
        |=> cpu_rsp.valid && !cpu_rsp.refused)
        else $error("permitted read refused");

    // a read of the lock byte returns the lock shadow
    a_lock_read_value: assert property (@(posedge clock) disable iff (rst)
        cpu_req.valid && !cpu_req.store && cpu_req.addr == LOCK_BYTE_ADDR
        |=> cpu_rsp.data == $past(lock_byte))
        else $error("lock byte read wrong");

    // stores with write enable low belong to data memory, not to flash
    a_store_no_enable: assert property (@(posedge clock) disable iff (rst)
        cpu_req.valid && cpu_req.store && !s_r.store_write_enable
        |-> cmd.op == OP_NONE ##1 !cpu_rsp.valid)
        else $error("store with write enable low reached flash");

    // a refused access never starts an operation
    a_refused_no_op: assert property (@(posedge clock) disable iff (rst)
        ev_err || ev_nokey || ev_guard |-> cmd.op == OP_NONE)
        else $error("refused access started an operation");

    // a program needs the unlock and write enable without erase enable
    a_prog_needs_key: assert property (@(posedge clock) disable iff (rst)
        cmd.op == OP_PROG |-> armed && s_r.store_write_enable && !s_r.store_erase_enable)
        else $error("program without unlock");

    // an unlocked erase of any ordinary page goes ahead
    a_erase_any_page: assert property (@(posedge clock) disable iff (rst)
        flash_store && armed && s_r.store_erase_enable && !lock_pg && !flg_is_reserved(cpu_req.addr)
        |-> cmd.op == OP_ERASE)
        else $error("permitted erase not started");

    // a lock byte write that changes nothing is let through
    a_lock_write_ok: assert property (@(posedge clock) disable iff (rst)
        flash_store && armed && !s_r.store_erase_enable && cpu_req.addr == LOCK_BYTE_ADDR
        && (cpu_req.data & lock_byte) == lock_byte |-> cmd.op == OP_PROG)
        else $error("permitted lock byte write refused");

    // a lock byte write that would lock more pages is flagged, with no reset
    a_lock_guard_flag: assert property (@(posedge clock) disable iff (rst)
        flash_store && armed && !s_r.store_erase_enable && cpu_req.addr == LOCK_BYTE_ADDR
        && (cpu_req.data & lock_byte) != lock_byte
        |=> s_r.status[ST_LOCK_GUARD] && cpu_rsp.refused && !flash_error_reset)
        else $error("lock byte change not flagged");

    // no lock byte bit ever goes back to one
    a_lock_frozen: assert property (@(posedge clock) disable iff (rst)
        (lock_byte & ~$past(lock_byte)) == '0)
        else $error("lock byte bit returned to one");

    // permitted accesses never raise the reset
    a_allowed_no_reset: assert property (@(posedge clock) disable iff (rst)
        cpu_req.valid && !flg_is_reserved(cpu_req.addr)
        && !(flash_store && armed && s_r.store_erase_enable && lock_pg) |=> !flash_error_reset)
        else $error("permitted access raised reset");

    function automatic logic status_err_set();
        return s_r.status[ST_FLASH_ERR];
    endfunction

endmodule // flg_guard

// ---- bench/flash_lock_access_guard_tb.sv ----
// self-checking bench for the flash lock access guard
`timescale 1ns/1ps
module flash_lock_access_guard_tb
    import flg_pkg::*;
;
    // design ports
    logic         clock;
    logic         rst;
    flg_wb_req_t  wb_req;
    flg_wb_rsp_t  wb_rsp;
    flg_cpu_req_t cpu_req;
    flg_cpu_rsp_t cpu_rsp;
    logic         flash_error_reset;
    logic         irq;
    // bench state
    int           num_errors;
    int           cmp_count;
    logic [31:0]  rd;
    flg_cpu_rsp_t rsp;
    logic         frst;

    flg_guard DUT (
        .clock             (clock),
        .rst               (rst),
        .wb_req            (wb_req),
        .wb_rsp            (wb_rsp),
        .cpu_req           (cpu_req),
        .cpu_rsp           (cpu_rsp),
        .flash_error_reset (flash_error_reset),
        .irq               (irq)
    );

    // 250 mhz system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // one comparison, counted; x never matches
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        cmp_count++;
        if (act !== exp) begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, act, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // classic wishbone cycle; held until ack is sampled high, bounded wait
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n = 0;
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        do begin
            @(posedge clock);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        q = wb_rsp.dat;
        wb_req <= '0;
        if (n >= 20) begin
            num_errors++;
            $display("Error at %0t: ack wait %0h limit %0h", $time, n, 20);
            finish_test();
        end
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, rd);
    endtask

    task automatic rdc(input logic [11:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0, rd);
        chk(rd, exp);
    endtask

    // one cpu request; response and reset pulse land one edge later
    task automatic cpu(input logic st, input logic [12:0] a, input logic [7:0] d);
        @(posedge clock);
        cpu_req <= '{valid: 1'b1, store: st, addr: a, data: d};
        @(posedge clock);
        cpu_req.valid <= 1'b0;
        #1;
        rsp  = cpu_rsp;
        frst = flash_error_reset;
    endtask

    // keys are spent by every store with write enable set, so each store gets a fresh pair
    task automatic kstore(input logic [12:0] a, input logic [7:0] d);
        wr(12'h240, 32'ha5);
        wr(12'h240, 32'hf1);
        cpu(1'b1, a, d);
    endtask

    // let register updates after a bus write reach irq
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic t_regs();
        rdc(12'h23c, 32'h0);
        wr(12'h23c, 32'hff);
        rdc(12'h23c, 32'h3);
        rdc(12'h3fc, 32'h0);
        wr(12'h24c, 32'h00);
        rdc(12'h24c, 32'hff);
    endtask

    task automatic t_erase();
        wr(12'h244, 32'hf);
        wr(12'h23c, 32'h3);
        kstore(13'h0010, 8'h12);
        chk(32'(rsp.valid), 32'h1);
        chk(32'(rsp.refused), 32'h0);
        cpu(1'b0, 13'h0000, 8'h0);
        chk(32'(rsp.data), 32'hff);
        cpu(1'b0, 13'h01ff, 8'h0);
        chk(32'(rsp.data), 32'hff);
        rdc(12'h244, 32'h8);
        rdc(12'h240, 32'h0);
        kstore(13'h1a00, 8'h00);
        cpu(1'b0, 13'h1bff, 8'h0);
        chk(32'(rsp.data), 32'hff);
    endtask

    task automatic t_program();
        wr(12'h23c, 32'h1);
        kstore(13'h0005, 8'h3c);
        cpu(1'b0, 13'h0005, 8'h0);
        chk(32'(rsp.data), 32'h3c);
        rdc(12'h23c, 32'h1);
        kstore(13'h0005, 8'hc3);
        cpu(1'b0, 13'h0005, 8'h0);
        chk(32'(rsp.data), 32'h00);
    endtask

    task automatic t_nokey();
        wr(12'h244, 32'hf);
        wr(12'h23c, 32'h0);
        kstore(13'h0006, 8'h00);
        chk(32'(rsp.valid), 32'h0);
        rdc(12'h240, 32'h2);
        wr(12'h240, 32'h0);
        wr(12'h23c, 32'h1);
        cpu(1'b1, 13'h0006, 8'h00);
        chk(32'(rsp.refused), 32'h1);
        cpu(1'b0, 13'h0006, 8'h0);
        chk(32'(rsp.data), 32'hff);
        rdc(12'h244, 32'h2);
    endtask

    task automatic t_lock();
        cpu(1'b0, 13'h1dff, 8'h0);
        chk(32'(rsp.data), 32'hff);
        wr(12'h244, 32'hf);
        kstore(13'h1dff, 8'hfe);
        chk(32'(rsp.refused), 32'h1);
        chk(32'(frst), 32'h0);
        rdc(12'h24c, 32'hff);
        rdc(12'h244, 32'h4);
        kstore(13'h1dff, 8'hff);
        chk(32'(rsp.refused), 32'h0);
        kstore(13'h1c00, 8'h00);
        chk(32'(rsp.refused), 32'h0);
        wr(12'h23c, 32'h3);
        kstore(13'h1c00, 8'h55);
        chk(32'(frst), 32'h1);
        cpu(1'b0, 13'h1c00, 8'h0);
        chk(32'(rsp.data), 32'h00);
    endtask

    task automatic t_reserved();
        cpu(1'b0, 13'h1e00, 8'h0);
        chk(32'(frst), 32'h1);
        chk(32'(rsp.refused), 32'h1);
        wr(12'h23c, 32'h1);
        kstore(13'h1fff, 8'h00);
        chk(32'(frst), 32'h1);
        wr(12'h23c, 32'h3);
        kstore(13'h1e10, 8'h00);
        chk(32'(frst), 32'h1);
    endtask

    // raise, mask and clear the level interrupt
    task automatic t_irq();
        wr(12'h244, 32'hf);
        wr(12'h248, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
        cpu(1'b0, 13'h1e00, 8'h0);
        settle();
        chk(32'(irq), 32'h1);
        wr(12'h248, 32'h0);
        settle();
        chk(32'(irq), 32'h0);
        wr(12'h248, 32'h1);
        settle();
        chk(32'(irq), 32'h1);
        wr(12'h244, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        num_errors = 0;
        cmp_count  = 0;
        rst        = 1'b1;
        wb_req     = '0;
        cpu_req    = '0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_erase();
        t_program();
        t_nokey();
        t_lock();
        t_reserved();
        t_irq();
        finish_test();
    end

endmodule // flash_lock_access_guard_tb
